//--- src/dsa_top.sv
// Debug scan access sequencer: scan chains on tck, injected instruction execution on clk.
// Assumes an outside TAP controller giving capture/shift/update/run-test pulses on tck,
// a memory and coprocessor port answering ext_ack, and one reset for both domains.
`timescale 1ns/1ps
module dsa_top
  import dsa_pkg::*;
(
  // Clocks and reset
  input  wire logic         clk,
  input  wire logic         tck,
  input  wire logic         arst_n,
  // Scan port controls, tck domain
  input  wire logic         tap_capture,
  input  wire logic         tap_shift,
  input  wire logic         tap_update,
  input  wire logic         tap_rti,
  input  wire logic [4:0]   tap_chain,
  input  wire dsa_ir_t      tap_ir,
  input  wire logic         tdi,
  output logic              tdo_ff,
  // Core status, clk domain
  input  wire logic         core_halted,
  input  wire logic         ext_imprecise,
  output logic [31:0]       csw_ff,
  output logic [31:0]       pc_ff,
  output logic [31:0]       abort_link_register_ff,
  output logic [31:0]       abort_saved_status_ff,
  // Memory and coprocessor port, clk domain
  output logic              ext_valid_ff,
  output dsa_ext_req_t      ext_req_ff,
  input  wire logic         ext_ack,
  input  wire logic         ext_abort,
  input  wire logic [31:0]  ext_rdata
);

  // ****************************************************************
  // Scan side (tck)
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_EXT, ST_GAP, ST_DONE} dsa_state_t;

  logic [SR_W-1:0] sr_ff;
  logic [SR_W-1:0] nxt_sr;
  logic [31:0]     injected_instruction_holder_ff;
  logic [31:0]     host_to_core_data_ff;
  logic [31:0]     core_to_host_data_ff;
  logic [31:0]     status_rd;
  logic [31:0]     c7_result_ff;
  logic [31:0]     dbg_rdata_ff;
  logic            exec_en_ff;
  logic            halt_mode_ff;
  logic            pabt_sticky_ff;
  logic            iabt_sticky_ff;
  logic            rdy_cap_ff;
  logic            c7_pend_ff;
  logic            go_tgl_ff;
  logic            done_tgl_ff;
  logic            pabt_tgl_ff;
  logic            iabt_tgl_ff;
  logic [3:0]      sync_s1_ff;
  logic [3:0]      sync_s2_ff;
  logic [1:0]      evt_s3_ff;
  logic            busy;
  logic            pabt_set;
  logic            iabt_set;
  logic            clr_sticky;
  logic [4:0]      eff;
  dsa_c7_req_t     c7_req;

  // Instruction-holder select overrides the chain number
  function automatic logic [4:0] eff_chain(input dsa_ir_t ir, input logic [4:0] ch);
    eff_chain = (ir == IR_SELECT_INSTRUCTION_HOLDER) ? CHAIN_INSTR : ch;
  endfunction

  // Highest bit index of a chain, where tdi enters during shift
  function automatic logic [5:0] chain_top(input logic [4:0] ch);
    unique case (ch)
      CHAIN_DATA:   chain_top = TOP_DATA;
      CHAIN_DBGREG: chain_top = TOP_DBGREG;
      CHAIN_INSTR:  chain_top = TOP_INSTR;
      default:      chain_top = TOP_STATUS;
    endcase
  endfunction

  assign eff        = eff_chain(tap_ir, tap_chain);
  assign busy       = go_tgl_ff != sync_s2_ff[3];
  assign pabt_set   = sync_s2_ff[2] ^ evt_s3_ff[1];
  assign iabt_set   = sync_s2_ff[1] ^ evt_s3_ff[0];
  assign clr_sticky = tap_capture && eff == CHAIN_STATUS && tap_ir == IR_INTEST;
  assign c7_req     = dsa_c7_req_t'(sr_ff);

  // Status word as seen from the scan side
  always_comb
  begin
    status_rd               = 32'h0000_0000;
    status_rd[ST_HALTED]    = sync_s2_ff[0];
    status_rd[ST_PABT]      = pabt_sticky_ff;
    status_rd[ST_IABT]      = iabt_sticky_ff;
    status_rd[ST_EXEC_EN]   = exec_en_ff;
    status_rd[ST_HALT_MODE] = halt_mode_ff;
  end

  // Capture loads the chain, shift moves it one place toward tdo
  always_comb
  begin
    nxt_sr = sr_ff;
    if (tap_capture)
    begin
      unique case (eff)
        CHAIN_DATA:   nxt_sr = {7'h00, core_to_host_data_ff, ~busy};
        CHAIN_DBGREG: nxt_sr = {7'h00, c7_result_ff, 1'b1};
        CHAIN_INSTR:  nxt_sr = {8'h00, injected_instruction_holder_ff};
        default:      nxt_sr = {8'h00, status_rd};
      endcase
    end
    else if (tap_shift)
    begin
      nxt_sr                 = {1'b0, sr_ff[SR_W-1:1]};
      nxt_sr[chain_top(eff)] = tdi;
    end
  end

  // Shift register and tdo; tdo comes from a flop so it is glitch free
  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sr_ff  <= '0;
      tdo_ff <= 1'b0;
    end
    else
    begin
      sr_ff  <= nxt_sr;
      tdo_ff <= nxt_sr[0];
    end
  end

  // Update writes; data and instruction are frozen while the core is busy
  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      injected_instruction_holder_ff <= 32'h0000_0000;
      host_to_core_data_ff           <= 32'h0000_0000;
      exec_en_ff                     <= 1'b0;
      halt_mode_ff                   <= 1'b0;
    end
    else if (tap_update)
    begin
      if (eff == CHAIN_INSTR && !busy)
        injected_instruction_holder_ff <= sr_ff[31:0];
      if (eff == CHAIN_DATA && tap_ir == IR_EXTEST && !busy)
        host_to_core_data_ff <= sr_ff[32:1];
      if (eff == CHAIN_STATUS && tap_ir == IR_EXTEST)
      begin
        exec_en_ff   <= sr_ff[ST_EXEC_EN];
        halt_mode_ff <= sr_ff[ST_HALT_MODE];
      end
    end
  end

  // Sticky abort flags: a set in the clearing cycle wins
  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pabt_sticky_ff <= 1'b0;
      iabt_sticky_ff <= 1'b0;
    end
    else
    begin
      pabt_sticky_ff <= pabt_set | (pabt_sticky_ff & ~clr_sticky);
      iabt_sticky_ff <= iabt_set | (iabt_sticky_ff & ~clr_sticky);
    end
  end

  // Ready capture and the gated run-test launch toward the core
  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdy_cap_ff <= 1'b1;
      go_tgl_ff  <= 1'b0;
    end
    else
    begin
      if (tap_capture && (eff == CHAIN_DATA || eff == CHAIN_INSTR))
        rdy_cap_ff <= ~busy;
      if (tap_rti && exec_en_ff && rdy_cap_ff && !pabt_sticky_ff && !busy)
        go_tgl_ff <= ~go_tgl_ff;
    end
  end

  // Core events into tck: done, precise, imprecise toggles and halted level
  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_s1_ff <= 4'h0;
      sync_s2_ff <= 4'h0;
      evt_s3_ff  <= 2'h0;
    end
    else
    begin
      sync_s1_ff <= {done_tgl_ff, pabt_tgl_ff, iabt_tgl_ff, core_halted};
      sync_s2_ff <= sync_s1_ff;
      evt_s3_ff  <= sync_s2_ff[2:1];
    end
  end

  // Debug register chain: result returned on the following scan
  dsa_regmem #(.AW(DBG_AW)) u_dbg_regs (
    .clk      (tck),
    .arst_n   (arst_n),
    .we       (tap_update && eff == CHAIN_DBGREG && c7_req.dir),
    .waddr    (c7_req.addr[DBG_AW-1:0]),
    .wdata    (c7_req.data),
    .raddr    (c7_req.addr[DBG_AW-1:0]),
    .rdata_ff (dbg_rdata_ff)
  );

  always_ff @(posedge tck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      c7_pend_ff   <= 1'b0;
      c7_result_ff <= 32'h0000_0000;
    end
    else
    begin
      c7_pend_ff <= tap_update && eff == CHAIN_DBGREG && !c7_req.dir;
      if (c7_pend_ff)
        c7_result_ff <= dbg_rdata_ff;
    end
  end

  // ****************************************************************
  // Core side (clk)
  // ****************************************************************
  dsa_state_t  state_ff;
  logic [3:0]  op_ff;
  logic [3:0]  rd_ff;
  logic [31:0] ptr_ff;
  logic [1:0]  gap_ff;
  logic [2:0]  go_s_ff;
  logic [31:0] rf_rdata_ff;
  logic [31:0] operand;
  logic        go_edge;
  logic        mem_abort;
  logic        rf_we;
  logic [3:0]  rf_waddr;
  logic [31:0] rf_wdata;
  logic [3:0]  rf_raddr;

  assign go_edge   = go_s_ff[1] ^ go_s_ff[2];
  assign operand   = (rd_ff == PC_IDX) ? pc_ff : rf_rdata_ff;
  assign mem_abort = state_ff == ST_EXT && ext_ack && ext_abort && ext_req_ff.kind == EXT_MEM;
  assign rf_raddr  = (injected_instruction_holder_ff[31:28] == OP_WORD_LOAD ||
                      injected_instruction_holder_ff[31:28] == OP_WORD_STORE) ?
                     PTR_IDX : injected_instruction_holder_ff[3:0];

  // Launch synchroniser; the holder is stable while the toggle is in flight
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      go_s_ff <= 3'h0;
    else
      go_s_ff <= {go_s_ff[1:0], go_tgl_ff};
  end

  // Core register file write select
  always_comb
  begin
    rf_we    = 1'b0;
    rf_waddr = rd_ff;
    rf_wdata = host_to_core_data_ff;
    if (state_ff == ST_EXEC && rd_ff != PC_IDX)
    begin
      rf_we = op_ff == OP_TO_CORE || op_ff == OP_STATUS_RD || op_ff == OP_PC_RD;
      if (op_ff == OP_STATUS_RD)
        rf_wdata = csw_ff;
      else if (op_ff == OP_PC_RD)
        rf_wdata = pc_ff;
    end
    else if (state_ff == ST_EXT && ext_ack && !mem_abort)
    begin
      if (ext_req_ff.kind == EXT_MEM)
      begin
        rf_we    = 1'b1;
        rf_waddr = PTR_IDX;
        rf_wdata = ptr_ff + PTR_STEP;
      end
      else if (!ext_req_ff.we && rd_ff != PC_IDX)
      begin
        rf_we    = 1'b1;
        rf_wdata = ext_rdata;
      end
    end
  end

  dsa_regmem #(.AW(4)) u_core_regs (
    .clk      (clk),
    .arst_n   (arst_n),
    .we       (rf_we),
    .waddr    (rf_waddr),
    .wdata    (rf_wdata),
    .raddr    (rf_raddr),
    .rdata_ff (rf_rdata_ff)
  );

  // Sequencer; the abort toggle leads done by a gap so the scan side sees it first
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff    <= ST_IDLE;
      op_ff       <= 4'h0;
      rd_ff       <= 4'h0;
      gap_ff      <= 2'h0;
      done_tgl_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (go_edge)
          begin
            op_ff    <= injected_instruction_holder_ff[31:28];
            rd_ff    <= (injected_instruction_holder_ff[31:28] == OP_WORD_LOAD ||
                         injected_instruction_holder_ff[31:28] == OP_WORD_STORE) ?
                        PTR_IDX : injected_instruction_holder_ff[3:0];
            state_ff <= ST_EXEC;
          end
        ST_EXEC:
          state_ff <= (op_ff == OP_WORD_LOAD || op_ff == OP_WORD_STORE ||
                       op_ff == OP_CP_TO_CORE || op_ff == OP_CORE_TO_CP) ? ST_EXT : ST_DONE;
        ST_EXT:
          if (ext_ack)
          begin
            gap_ff   <= ABT_GAP;
            state_ff <= mem_abort ? ST_GAP : ST_DONE;
          end
        ST_GAP:
          if (gap_ff == 2'h0)
            state_ff <= ST_DONE;
          else
            gap_ff <= gap_ff - 2'h1;
        ST_DONE:
        begin
          done_tgl_ff <= ~done_tgl_ff;
          state_ff    <= ST_IDLE;
        end
      endcase
    end
  end

  // External request; memory addresses are word aligned, no sub-word size exists
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_valid_ff <= 1'b0;
      ext_req_ff   <= '0;
      ptr_ff       <= 32'h0000_0000;
    end
    else if (state_ff == ST_EXEC && (op_ff == OP_WORD_LOAD || op_ff == OP_WORD_STORE))
    begin
      ext_valid_ff     <= 1'b1;
      ptr_ff           <= operand;
      ext_req_ff.kind  <= EXT_MEM;
      ext_req_ff.we    <= op_ff == OP_WORD_STORE;
      ext_req_ff.addr  <= {operand[31:2], 2'b00};
      ext_req_ff.wdata <= host_to_core_data_ff;
    end
    else if (state_ff == ST_EXEC && (op_ff == OP_CP_TO_CORE || op_ff == OP_CORE_TO_CP))
    begin
      ext_valid_ff     <= 1'b1;
      ext_req_ff.kind  <= EXT_CP;
      ext_req_ff.we    <= op_ff == OP_CORE_TO_CP;
      ext_req_ff.addr  <= {24'h00_0000, injected_instruction_holder_ff[11:4]};
      ext_req_ff.wdata <= operand;
    end
    else if (ext_ack)
      ext_valid_ff <= 1'b0;
  end

  // Status word, program counter and abort entry
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      csw_ff                 <= CSW_RST;
      pc_ff                  <= PC_RST;
      abort_link_register_ff <= 32'h0000_0000;
      abort_saved_status_ff  <= 32'h0000_0000;
    end
    else if (mem_abort)
    begin
      abort_link_register_ff <= pc_ff;
      abort_saved_status_ff  <= csw_ff;
      csw_ff[4:0]            <= MODE_ABT;
    end
    else if (state_ff == ST_EXEC)
    begin
      if (op_ff == OP_TO_CORE && rd_ff == PC_IDX)
        csw_ff[31:28] <= host_to_core_data_ff[31:28];
      else if (op_ff == OP_STATUS_WR)
        csw_ff <= operand;
      else if (op_ff == OP_PC_WR)
        pc_ff <= operand;
    end
    else if (state_ff == ST_EXT && ext_ack && ext_req_ff.kind == EXT_CP &&
             !ext_req_ff.we && rd_ff == PC_IDX)
      csw_ff[31:28] <= ext_rdata[31:28];
  end

  // Read data toward the host, and abort event toggles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_to_host_data_ff <= 32'h0000_0000;
      pabt_tgl_ff          <= 1'b0;
      iabt_tgl_ff          <= 1'b0;
    end
    else
    begin
      if (state_ff == ST_EXEC && op_ff == OP_FROM_CORE)
        core_to_host_data_ff <= operand;
      else if (state_ff == ST_EXT && ext_ack && !mem_abort && ext_req_ff.kind == EXT_MEM &&
               !ext_req_ff.we)
        core_to_host_data_ff <= ext_rdata;
      if (mem_abort)
        pabt_tgl_ff <= ~pabt_tgl_ff;
      if (ext_imprecise)
        iabt_tgl_ff <= ~iabt_tgl_ff;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  ptr_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_EXT && ext_ack && !ext_abort && ext_req_ff.kind == EXT_MEM)
    |-> (rf_we && rf_waddr == PTR_IDX && rf_wdata == ptr_ff + PTR_STEP))
    else $error("pointer not advanced by four");

  store_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_EXEC && op_ff == OP_WORD_STORE)
    |=> (ext_valid_ff && ext_req_ff.we && ext_req_ff.wdata == host_to_core_data_ff))
    else $error("store request lacks host data");

  abort_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
    mem_abort |=> (csw_ff[4:0] == MODE_ABT && abort_saved_status_ff == $past(csw_ff)
                   && abort_link_register_ff == $past(pc_ff)))
    else $error("abort entry not taken");

  abort_noinc_a: assert property (@(posedge clk) disable iff (!arst_n)
    mem_abort |-> !rf_we ##1 (state_ff == ST_GAP)[*3] ##1 state_ff == ST_DONE)
    else $error("pointer moved or gap wrong after abort");

  pc_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_EXEC && op_ff == OP_TO_CORE && rd_ff == PC_IDX)
    |=> ($stable(pc_ff) && csw_ff[31:28] == $past(host_to_core_data_ff[31:28])))
    else $error("move to register 15 touched the program counter");

  mode_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_EXEC && op_ff == OP_STATUS_WR) |=> csw_ff == $past(operand))
    else $error("status word write refused");

  word_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ext_valid_ff && ext_req_ff.kind == EXT_MEM) |-> ext_req_ff.addr[1:0] == 2'b00)
    else $error("sub-word memory access");

  sticky_clear_a: assert property (@(posedge tck) disable iff (!arst_n)
    (clr_sticky && !pabt_set && !iabt_set) |=> (!pabt_sticky_ff && !iabt_sticky_ff))
    else $error("status read left a sticky flag set");

  rti_gate_a: assert property (@(posedge tck) disable iff (!arst_n)
    (tap_rti && (!exec_en_ff || !rdy_cap_ff || pabt_sticky_ff)) |=> $stable(go_tgl_ff))
    else $error("instruction launched while gated");

  c7_return_a: assert property (@(posedge tck) disable iff (!arst_n)
    (tap_update && eff == CHAIN_DBGREG && !c7_req.dir)
    |=> ##1 c7_result_ff == $past(dbg_rdata_ff))
    else $error("debug register result not kept");

endmodule

//--- src/dsa_pkg.sv
// Shared constants and types of the debug scan access sequencer.
// Assumes a TAP controller outside that decodes the scan instruction and chain number.
package dsa_pkg;

  // ****************************************************************
  // Scan chains and lengths
  // ****************************************************************
  localparam logic [4:0] CHAIN_STATUS = 5'h01;
  localparam logic [4:0] CHAIN_INSTR  = 5'h04;
  localparam logic [4:0] CHAIN_DATA   = 5'h05;
  localparam logic [4:0] CHAIN_DBGREG = 5'h07;
  localparam int         SR_W         = 40;
  localparam logic [5:0] TOP_STATUS   = 6'h1F; // Last bit index of each chain
  localparam logic [5:0] TOP_INSTR    = 6'h1F;
  localparam logic [5:0] TOP_DATA     = 6'h20;
  localparam logic [5:0] TOP_DBGREG   = 6'h27;

  // ****************************************************************
  // Debug status/control bit positions
  // ****************************************************************
  localparam int ST_HALTED    = 0;
  localparam int ST_PABT      = 6;
  localparam int ST_IABT      = 7;
  localparam int ST_EXEC_EN   = 13;
  localparam int ST_HALT_MODE = 14;

  // ****************************************************************
  // Injected instruction encoding and core constants
  // ****************************************************************
  localparam logic [3:0] OP_WORD_LOAD  = 4'h1;
  localparam logic [3:0] OP_WORD_STORE = 4'h2;
  localparam logic [3:0] OP_TO_CORE    = 4'h3;
  localparam logic [3:0] OP_FROM_CORE  = 4'h4;
  localparam logic [3:0] OP_STATUS_WR  = 4'h5;
  localparam logic [3:0] OP_STATUS_RD  = 4'h6;
  localparam logic [3:0] OP_PC_WR      = 4'h7;
  localparam logic [3:0] OP_PC_RD      = 4'h8;
  localparam logic [3:0] OP_CP_TO_CORE = 4'h9;
  localparam logic [3:0] OP_CORE_TO_CP = 4'hA;
  localparam logic [3:0] PTR_IDX       = 4'h0;
  localparam logic [3:0] PC_IDX        = 4'hF;
  localparam logic [31:0] PTR_STEP     = 32'h0000_0004;
  localparam logic [4:0] MODE_ABT      = 5'h17;
  localparam logic [31:0] CSW_RST      = 32'h0000_01D3;
  localparam logic [31:0] PC_RST       = 32'h0000_0000;
  localparam logic [1:0] ABT_GAP       = 2'h2; // Gap count load; the sequencer stays three core cycles in ST_GAP
  localparam int         DBG_AW        = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {IR_BYPASS, IR_INTEST, IR_EXTEST, IR_SELECT_INSTRUCTION_HOLDER} dsa_ir_t;
  typedef enum logic {EXT_MEM, EXT_CP} dsa_ext_kind_t;

  typedef struct packed {
    dsa_ext_kind_t kind;
    logic          we;
    logic [31:0]   addr;
    logic [31:0]   wdata;
  } dsa_ext_req_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic [31:0] data;
    logic        dir;
  } dsa_c7_req_t;

endpackage

//--- src/dsa_regmem.sv
// Small register memory with one write port and a registered read port.
// Assumes both ports sit in the clock domain of clk.
`timescale 1ns/1ps
module dsa_regmem #(
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Write port
  input  wire logic              we,
  input  wire logic [AW-1:0]     waddr,
  input  wire logic [31:0]       wdata,
  // Read port, data one cycle after the address
  input  wire logic [AW-1:0]     raddr,
  output logic      [31:0]       rdata_ff
);

  logic [31:0] mem [2**AW];

  // Storage array carries no reset, which keeps it a plain RAM
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Registered read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= mem[raddr];
  end

endmodule

//--- dv/dsa_mem_model.sv
// Memory and coprocessor responder on the far side of the core port.
// Assumes each request is held until ext_ack; answers alternate fast and slow.
// No instruction cache sits behind this responder, so stores need no invalidation.
`timescale 1ns/1ps
module dsa_mem_model
  import dsa_pkg::*;
#(parameter logic [31:0] ABT_ADDR = 32'h0000_0F00)
(
  // Core port
  input  wire logic         clk,
  input  wire logic         ext_valid_ff,
  input  wire dsa_ext_req_t ext_req_ff,
  output logic              ext_ack = 1'b0,
  output logic              ext_abort = 1'b0,
  output logic [31:0]       ext_rdata = 32'h0,
  output dsa_ext_req_t      last_req = '0
);
  logic [1:0] wait_ff = 2'h0;
  logic       slow_ff = 1'b0;
  // Read data wobbles outside an answer, so a stale value is never trusted
  always @(posedge clk)
  begin
    ext_ack   <= 1'b0;
    ext_abort <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (ext_valid_ff && !ext_ack)
    begin
      wait_ff <= wait_ff + 2'h1;
      if (wait_ff == {slow_ff, 1'b0})
      begin
        ext_ack   <= 1'b1;
        ext_abort <= ext_req_ff.addr == ABT_ADDR; // One faulting address
        ext_rdata <= ~ext_req_ff.addr;
        last_req  <= ext_req_ff;
        wait_ff   <= 2'h0;
        slow_ff   <= ~slow_ff;
      end
    end
  end
endmodule

//--- dv/test_debug_scan_access_sequencer.sv
// Self-checking bench for the debug scan access sequencer.
// Assumes dsa_top and the responder model; scans are driven on tck.
`timescale 1ns/1ps
module test_debug_scan_access_sequencer;
  import dsa_pkg::*;
  logic clk = 0, tck = 0, arst_n = 0, tap_capture = 0, tap_shift = 0, tap_update = 0;
  logic tap_rti = 0, tdi = 0, tdo_ff, ext_valid_ff, ext_ack, ext_abort, ext_imprecise = 0;
  logic [4:0]  tap_chain = 5'h0;
  dsa_ir_t     tap_ir = IR_BYPASS;
  logic [31:0] csw_ff, pc_ff, abort_link_register_ff, abort_saved_status_ff, ext_rdata, c0, p0;
  dsa_ext_req_t ext_req_ff, last_req;
  logic [39:0] o;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  localparam logic [31:0] ABT = 32'h0000_0F00;
  always #12.5 clk = ~clk;
  always #16 tck = ~tck;
  dsa_top i_dut (.clk, .tck, .arst_n, .tap_capture, .tap_shift, .tap_update, .tap_rti,
    .tap_chain, .tap_ir, .tdi, .tdo_ff, .core_halted(1'b1), .ext_imprecise, .csw_ff, .pc_ff,
    .abort_link_register_ff, .abort_saved_status_ff, .ext_valid_ff, .ext_req_ff, .ext_ack,
    .ext_abort, .ext_rdata);
  dsa_mem_model #(.ABT_ADDR(ABT)) i_mem (.clk, .ext_valid_ff, .ext_req_ff, .ext_ack,
    .ext_abort, .ext_rdata, .last_req);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  // Capture, shift LSB first sampling tdo between edges, then update
  task automatic scan(logic [4:0] c, dsa_ir_t ir, logic [5:0] top, logic [39:0] d);
    @(posedge tck);
    tap_chain <= c;
    tap_ir <= ir;
    tap_capture <= 1'b1;
    @(posedge tck);
    tap_capture <= 1'b0;
    tap_shift <= 1'b1;
    tdi <= d[0];
    for (int i = 0; i <= top; i++)
    begin
      @(negedge tck);
      o[i] = tdo_ff;
      d = d >> 1;
      @(posedge tck);
      tdi <= d[0];
    end
    tap_shift <= 1'b0;
    tap_update <= 1'b1;
    @(posedge tck);
    tap_update <= 1'b0;
  endtask
  // Instruction, data word, run-test, then poll ready; the wait covers the crossing
  task automatic exe(logic [3:0] op, logic [3:0] rg, logic [31:0] d);
    scan(CHAIN_INSTR, IR_SELECT_INSTRUCTION_HOLDER, TOP_INSTR, {8'h0, op, 24'h0, rg});
    scan(CHAIN_DATA, IR_EXTEST, TOP_DATA, {7'h0, d, 1'b0});
    @(posedge tck) tap_rti <= 1'b1;
    @(posedge tck) tap_rti <= 1'b0;
    repeat (6) @(posedge tck);
    o[0] = 1'b0;
    for (int k = 0; k < 20 && o[0] !== 1'b1; k++)
      scan(CHAIN_DATA, IR_INTEST, TOP_DATA, 40'h0);
    chk("ready", 32'h1, {31'h0, o[0]});
  endtask
  task automatic t_init;
    chk("csw reset", CSW_RST, csw_ff);
    chk("pc reset", PC_RST, pc_ff);
    @(posedge clk) arst_n <= 1'b1;
    scan(CHAIN_STATUS, IR_EXTEST, TOP_STATUS, 40'h6000);
    scan(CHAIN_STATUS, IR_INTEST, TOP_STATUS, 40'h0);
    chk("enables", 32'h6001, o[31:0] & 32'h6001);
    $display("init test done");
  endtask
  task automatic t_mem;
    exe(OP_TO_CORE, PTR_IDX, 32'h0000_0100);
    exe(OP_WORD_STORE, PTR_IDX, 32'hCAFE_0001);
    chk("store addr", 32'h0000_0100, last_req.addr);
    chk("store data", 32'hCAFE_0001, last_req.wdata);
    exe(OP_WORD_LOAD, PTR_IDX, 32'h0);
    chk("load addr", 32'h0000_0104, last_req.addr);
    chk("load data", ~32'h0000_0104, o[32:1]);
    exe(OP_WORD_LOAD, PTR_IDX, 32'h0);
    chk("load next", 32'h0000_0108, last_req.addr);
    $display("memory test done");
  endtask
  task automatic t_csw;
    exe(OP_TO_CORE, 4'h1, 32'h0000_0010);
    exe(OP_STATUS_WR, 4'h1, 32'h0);
    exe(OP_TO_CORE, 4'h1, 32'h0000_003F);
    exe(OP_STATUS_WR, 4'h1, 32'h0);
    chk("mode write", 32'h0000_003F, csw_ff);
    exe(OP_CORE_TO_CP, 4'h1, 32'h0);
    chk("cp kind", 32'h3, {30'h0, last_req.kind, last_req.we});
    chk("cp data", 32'h0000_003F, last_req.wdata);
    p0 = pc_ff;
    exe(OP_CP_TO_CORE, PC_IDX, 32'h0);
    chk("pc kept", p0, pc_ff);
    chk("flags", {~last_req.addr[31:28], 28'h000_003F}, csw_ff);
    exe(OP_TO_CORE, PC_IDX, 32'h5000_0000);
    chk("pc kept r15", p0, pc_ff);
    chk("flags r15", 32'h5000_003F, csw_ff);
    exe(OP_TO_CORE, 4'h2, 32'h0000_0200);
    exe(OP_PC_WR, 4'h2, 32'h0);
    chk("pc write", 32'h0000_0200, pc_ff);
    exe(OP_PC_RD, 4'h3, 32'h0);
    exe(OP_FROM_CORE, 4'h3, 32'h0);
    chk("pc read", 32'h0000_0200, o[32:1]);
    exe(OP_STATUS_RD, 4'h3, 32'h0);
    exe(OP_FROM_CORE, 4'h3, 32'h0);
    chk("status read", 32'h5000_003F, o[32:1]);
    $display("status test done");
  endtask
  task automatic t_abt;
    exe(OP_TO_CORE, PTR_IDX, ABT);
    c0 = csw_ff;
    p0 = pc_ff;
    exe(OP_WORD_LOAD, PTR_IDX, 32'h0);
    chk("abort mode", {27'h0, MODE_ABT}, {27'h0, csw_ff[4:0]});
    chk("abort link", p0, abort_link_register_ff);
    chk("abort saved", c0, abort_saved_status_ff);
    exe(OP_WORD_STORE, PTR_IDX, 32'h5);
    chk("blocked", 32'h0, {31'h0, last_req.we});
    @(posedge clk) ext_imprecise <= 1'b1;
    @(posedge clk) ext_imprecise <= 1'b0;
    repeat (4) @(posedge tck);
    scan(CHAIN_STATUS, IR_INTEST, TOP_STATUS, 40'h0);
    chk("sticky set", 32'hC0, o[31:0] & 32'hC0);
    scan(CHAIN_STATUS, IR_INTEST, TOP_STATUS, 40'h0);
    chk("sticky clear", 32'h0, o[31:0] & 32'hC0);
    exe(OP_FROM_CORE, PTR_IDX, 32'h0);
    chk("pointer kept", ABT, o[32:1]);
    exe(OP_TO_CORE, PTR_IDX, 32'h0000_0200);
    exe(OP_WORD_LOAD, PTR_IDX, 32'h0);
    chk("restart addr", 32'h0000_0200, last_req.addr);
    chk("restart data", ~32'h0000_0200, o[32:1]);
    $display("abort test done");
  endtask
  task automatic t_c7;
    scan(CHAIN_DBGREG, IR_EXTEST, TOP_DBGREG, {7'h3, 32'h1234_5678, 1'b1});
    scan(CHAIN_DBGREG, IR_EXTEST, TOP_DBGREG, {7'h3, 32'h0, 1'b0});
    o[0] = 1'b0;
    for (int k = 0; k < 8 && o[0] !== 1'b1; k++)
      scan(CHAIN_DBGREG, IR_EXTEST, TOP_DBGREG, 40'h0);
    chk("c7 ready", 32'h1, {31'h0, o[0]});
    chk("debug reg", 32'h1234_5678, o[32:1]);
    $display("chain7 test done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    t_init;
    t_mem;
    t_csw;
    t_abt;
    t_c7;
    complete_run;
  end
endmodule
